// File: verilog/irqrc_unit.sv
/*
 * Interrupt request logic and reset-cause recording, with an Avalon-MM slave.
 * Assumes the core flags each instruction slot after any multi-cycle instruction ends,
 * and that watchdog, brown-out and pin reset events arrive as pulses on sys_clk.
 * sys_rst is the power-on reset.
 */
// Contract
// [RULE_01] watchdog reset sets bit 3; power-on or writing zero clears it
// [RULE_02] brown-out reset sets bit 2; power-on or writing zero clears it
// [RULE_03] pin reset sets bit 1; power-on or writing zero clears it
// [RULE_04] power-on sets bit 0; only writing zero clears it
// [RULE_05] software reads then clears reset causes early after start
// [RULE_06] bandgap on when brown-out fuse, comparator select or converter enabled
// [RULE_07] software waits reference start-up, 10 us, before using comparator
// [RULE_08] entry clears global enable; return sets it again
// [RULE_09] loading a vector clears the flag that caused it
// [RULE_10] flag sets even while its enable is clear, stays until served or cleared
// [RULE_11] flags pend while global enable clear, then served by priority
// [RULE_12] low-level external request has no flag, lasts while pin low
// [RULE_13] entry takes four cycles, pushes 9-bit pc, then vector
// [RULE_14] a multi-cycle instruction completes before entry starts
// [RULE_15] entry from sleep takes four extra cycles
// [RULE_16] return takes four cycles and pops the 9-bit pc
// [RULE_17] one main instruction runs after return before next entry
// [RULE_18] external pin interrupt enable bit 6, vector 001
// [RULE_19] pin change enable bit 5, any pin change, vector 002
// [RULE_20] external request comes from pin level even when driven as output
// [RULE_21] external flag set by edge or change, cleared by vector or write one
// [RULE_22] pin change flag bit 5, cleared by vector or write one
// [RULE_23] sense field: 00 low level, 01 any change, 10 falling edge
// [RULE_24] lowest vector wins: external, pin change, then timers
`default_nettype none
module irqrc_unit
	import irqrc_pkg::*;
#(
	parameter int REF_WAIT_CYCLES = REF_STARTUP_CYCLES
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// processor core
	input wire irqrc_core_in_type core_in,
	output irqrc_core_out_type core_out,
	// pins and reset sources
	input wire logic ext_pin,
	input wire logic [PIN_COUNT-1:0] port_pins,
	input wire logic wdt_reset_evt,
	input wire logic bod_reset_evt,
	input wire logic pin_reset_evt,
	input wire logic brownout_detect_fuse,
	// timer requests, flags kept in the timer block
	input wire logic [2:0] timer_irq_req,
	// analog
	output logic bandgap_on
);
	// the start-up counter is eight bits wide, so longer waits cannot be served
	if (REF_WAIT_CYCLES < 1 || REF_WAIT_CYCLES > 255) begin : g_bad_ref_wait
		$error("REF_WAIT_CYCLES must lie in 1..255");
	end

	irqrc_state_type st_q;
	irqrc_state_type st_d;
	logic [5:0] idx;
	logic bus_hit;
	logic wr_go;
	logic entry_take;
	logic pc_evt;
	logic [NUM_SRC-1:0] req;

	function automatic logic [2:0] pick_src(input logic [NUM_SRC-1:0] r);
		logic [2:0] s;
		s = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (r[i]) begin
				s = 3'(i);
			end
		end
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus decode: one wait cycle per access so read data come from flops
	assign idx = address[7:2];
	assign bus_hit = (address[1:0] == 2'h0);
	assign wr_go = write && st_q.ack && ce && bus_hit && byteenable[0];
	assign waitrequest = (read || write) && !(st_q.ack && ce);
	assign readdata = {24'h0, st_q.rdata};

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic ext_chg;
		logic ext_evt;
		logic ext_level_req;
		logic [PIN_COUNT-1:0] pin_chg;
		logic clr_ext;
		logic clr_pc;
		logic [3:0] cause_set;
		logic [7:0] rd;
		ext_chg = 1'b0;
		ext_evt = 1'b0;
		ext_level_req = 1'b0;
		pin_chg = '0;
		clr_ext = 1'b0;
		clr_pc = 1'b0;
		cause_set = 4'h0;
		rd = 8'h00;
		st_d = st_q;
		st_d.push = 1'b0;
		st_d.pop = 1'b0;
		st_d.vload = 1'b0;
		st_d.timer_ack = 3'h0;
		entry_take = 1'b0;

		// three-stage synchronisers; a change counts once stages two and three agree
		// [RULE_20] pin level sampled
		st_d.ext_s1 = ext_pin;
		st_d.ext_s2 = st_q.ext_s1;
		st_d.ext_s3 = st_q.ext_s2;
		ext_chg = (st_q.ext_s2 == st_q.ext_s3) && (st_q.ext_s3 != st_q.ext_stable);
		if (ext_chg) begin
			st_d.ext_stable = st_q.ext_s3;
		end
		st_d.pin_s1 = port_pins;
		st_d.pin_s2 = st_q.pin_s1;
		st_d.pin_s3 = st_q.pin_s2;
		pin_chg = ~(st_q.pin_s2 ^ st_q.pin_s3) & (st_q.pin_s3 ^ st_q.pin_stable);
		st_d.pin_stable = st_q.pin_stable ^ pin_chg;
		pc_evt = |pin_chg;

		// [RULE_23] sense select
		case (st_q.sense)
			SENSE_LOW: ext_evt = 1'b0;
			SENSE_ANY: ext_evt = ext_chg;
			SENSE_FALL: ext_evt = ext_chg && !st_q.ext_s3;
			default: ext_evt = ext_chg && st_q.ext_s3;
		endcase
		// [RULE_12] level request
		ext_level_req = (st_q.sense == SENSE_LOW) && !st_q.ext_stable;

		// [RULE_18] [RULE_19] enables gate requests
		req[0] = st_q.en_ext && ((st_q.sense == SENSE_LOW) ? ext_level_req : st_q.ext_flag);
		req[1] = st_q.en_pc && st_q.pc_flag;
		req[4:2] = timer_irq_req;

		case (st_q.fsm)
			IRQRC_IDLE: begin
				if (core_in.return_from_interrupt) begin
					// [RULE_16] return pops pc
					st_d.fsm = IRQRC_RET;
					st_d.cnt = RETURN_CYCLES - 4'h1;
					st_d.pop = 1'b1;
				// [RULE_14] [RULE_11] [RULE_17] take at a slot
				end else if (core_in.slot && st_q.gie && (|req) && !st_q.need_instr) begin
					entry_take = 1'b1;
					st_d.fsm = IRQRC_ENTRY;
					// [RULE_08] entry masks all
					st_d.gie = 1'b0;
					// [RULE_24] lowest vector wins
					st_d.src = pick_src(req);
					// [RULE_13] [RULE_15] entry length
					st_d.slow = core_in.sleeping;
					st_d.cnt = (core_in.sleeping ? ENTRY_CYCLES + SLEEP_EXTRA_CYCLES : ENTRY_CYCLES) - 4'h1;
					st_d.push = 1'b1;
					st_d.push_pc = core_in.pc;
				end else begin
					if (core_in.slot) begin
						st_d.need_instr = 1'b0;
					end
					if (core_in.gie_set) begin
						st_d.gie = 1'b1;
					end else if (core_in.gie_clr) begin
						st_d.gie = 1'b0;
					end
				end
			end
			IRQRC_ENTRY: begin
				if (st_q.cnt == 4'h0) begin
					st_d.fsm = IRQRC_IDLE;
					st_d.vload = 1'b1;
					// [RULE_18] [RULE_19] vector address
					st_d.vector = VEC_EXT + 9'(st_q.src);
					// [RULE_09] hardware clear on vector
					clr_ext = (st_q.src == 3'h0);
					clr_pc = (st_q.src == 3'h1);
					st_d.timer_ack = (st_q.src >= 3'h2) ? 3'(3'h1 << (st_q.src - 3'h2)) : 3'h0;
				end else begin
					st_d.cnt = st_q.cnt - 4'h1;
				end
			end
			IRQRC_RET: begin
				if (st_q.cnt == 4'h0) begin
					st_d.fsm = IRQRC_IDLE;
					// [RULE_08] return re-enables
					st_d.gie = 1'b1;
					st_d.need_instr = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt - 4'h1;
				end
			end
			default: st_d.fsm = IRQRC_IDLE;
		endcase

		// register writes
		if (wr_go && idx == IDX_RESET_CAUSE) begin
			// [RULE_01] [RULE_02] [RULE_03] [RULE_04] writing zero clears
			st_d.cause = st_q.cause & writedata[3:0];
		end
		if (wr_go && idx == IDX_MASK) begin
			st_d.en_ext = writedata[EXT_BIT];
			st_d.en_pc = writedata[PC_BIT];
		end
		if (wr_go && idx == IDX_FLAGS) begin
			clr_ext = clr_ext || writedata[EXT_BIT];
			clr_pc = clr_pc || writedata[PC_BIT];
		end
		if (wr_go && idx == IDX_SENSE) begin
			st_d.sense = writedata[1:0];
		end
		if (wr_go && idx == IDX_REF) begin
			st_d.conv_en = writedata[CONV_BIT];
			st_d.cbs = writedata[CBS_BIT];
		end

		// reset causes: a set wins over a same-cycle clear
		// [RULE_01] [RULE_02] [RULE_03] set on event
		cause_set[WDT_BIT] = wdt_reset_evt;
		cause_set[BOD_BIT] = bod_reset_evt;
		cause_set[PINRST_BIT] = pin_reset_evt;
		st_d.cause = st_d.cause | cause_set;

		// [RULE_10] [RULE_21] [RULE_22] sticky flags, set wins
		st_d.ext_flag = ((st_q.ext_flag && !clr_ext) || ext_evt) && (st_d.sense != SENSE_LOW);
		st_d.pc_flag = (st_q.pc_flag && !clr_pc) || pc_evt;

		// [RULE_06] bandgap enable
		st_d.bg_on = brownout_detect_fuse || st_q.cbs || st_q.conv_en;
		// ready status so software can see start-up has elapsed
		if (!st_q.bg_on) begin
			st_d.ref_cnt = 8'h00;
			st_d.ref_ready = 1'b0;
		end else if (st_q.ref_cnt == 8'(REF_WAIT_CYCLES - 1)) begin
			st_d.ref_ready = 1'b1;
		end else begin
			st_d.ref_cnt = st_q.ref_cnt + 8'h01;
		end

		// bus answer
		if ((read || write) && !st_q.ack) begin
			st_d.ack = 1'b1;
			if (bus_hit) begin
				case (idx)
					IDX_RESET_CAUSE: rd = {4'h0, st_q.cause};
					IDX_MASK: begin
						rd[EXT_BIT] = st_q.en_ext;
						rd[PC_BIT] = st_q.en_pc;
					end
					IDX_FLAGS: begin
						rd[EXT_BIT] = st_q.ext_flag;
						rd[PC_BIT] = st_q.pc_flag;
					end
					IDX_SENSE: rd = {6'h00, st_q.sense};
					IDX_REF: rd = {3'h0, st_q.gie, st_q.ref_ready, st_q.bg_on, st_q.cbs, st_q.conv_en};
					default: rd = 8'h00;
				endcase
			end
			st_d.rdata = rd;
		end else begin
			st_d.ack = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= IRQRC_STATE_RST;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign core_out.hold = (st_q.fsm != IRQRC_IDLE);
	assign core_out.push = st_q.push;
	assign core_out.pop = st_q.pop;
	assign core_out.push_pc = st_q.push_pc;
	assign core_out.vector_load = st_q.vload;
	assign core_out.vector = st_q.vector;
	assign core_out.gie = st_q.gie;
	assign core_out.timer_ack = st_q.timer_ack;
	assign bandgap_on = st_q.bg_on;

	////////////////////////////////////////////////////////////////////////////////
	// checks; busy_cyc counts enabled cycles spent away from idle
	logic [3:0] busy_cyc;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_cyc <= 4'h0;
		end else if (ce) begin
			busy_cyc <= (st_q.fsm == IRQRC_IDLE) ? 4'h0 : busy_cyc + 4'h1;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	property p_wdt_set;
		ce && wdt_reset_evt |=> st_q.cause[WDT_BIT];
	endproperty
	a_wdt_set: assert property (p_wdt_set) else $error("watchdog cause not recorded"); // RULE_01

	property p_por_hold;
		ce && st_q.cause[POR_BIT] && !(wr_go && idx == IDX_RESET_CAUSE) |=> st_q.cause[POR_BIT];
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("power-on cause lost"); // RULE_04

	property p_bandgap;
		ce |=> bandgap_on == $past(brownout_detect_fuse || st_q.cbs || st_q.conv_en);
	endproperty
	a_bandgap: assert property (p_bandgap) else $error("bandgap enable wrong"); // RULE_06

	property p_entry_mask;
		ce && entry_take |=> !st_q.gie && core_out.hold && core_out.push;
	endproperty
	a_entry_mask: assert property (p_entry_mask) else $error("entry did not mask"); // RULE_08

	property p_pc_clear;
		ce && st_q.fsm == IRQRC_ENTRY && st_q.cnt == 4'h0 && st_q.src == 3'h1 && !pc_evt
			|=> !st_q.pc_flag && core_out.vector == VEC_PC;
	endproperty
	a_pc_clear: assert property (p_pc_clear) else $error("pin change flag not cleared"); // RULE_09

	property p_pending;
		!st_q.gie |-> !entry_take;
	endproperty
	a_pending: assert property (p_pending) else $error("entry with global enable clear"); // RULE_11

	property p_entry_len;
		core_out.vector_load |-> busy_cyc == (st_q.slow ? ENTRY_CYCLES + SLEEP_EXTRA_CYCLES : ENTRY_CYCLES);
	endproperty
	a_entry_len: assert property (p_entry_len) else $error("entry length wrong"); // RULE_13

	property p_ret_len;
		st_q.fsm == IRQRC_RET && st_q.cnt == 4'h0 |-> busy_cyc == RETURN_CYCLES - 4'h1;
	endproperty
	a_ret_len: assert property (p_ret_len) else $error("return length wrong"); // RULE_16

	property p_ret_pop;
		ce && core_in.return_from_interrupt && st_q.fsm == IRQRC_IDLE |=> core_out.pop && core_out.hold;
	endproperty
	a_ret_pop: assert property (p_ret_pop) else $error("return did not pop"); // RULE_16

	property p_one_instr;
		st_q.need_instr |-> !entry_take;
	endproperty
	a_one_instr: assert property (p_one_instr) else $error("entry before one instruction"); // RULE_17

	property p_level_noflag;
		st_q.sense == SENSE_LOW |-> !st_q.ext_flag;
	endproperty
	a_level_noflag: assert property (p_level_noflag) else $error("flag set in level mode"); // RULE_12
endmodule // irqrc_unit
`default_nettype wire

// File: verilog/irqrc_pkg.sv
/*
 * Package of the interrupt and reset-cause unit: register indices, field positions,
 * reset values, timing counts, state and carrier types.
 * Assumes a 20 MHz system clock and a byte-addressed 32-bit register bus.
 */
`default_nettype none
package irqrc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_RESET_CAUSE = 6'h34;
	localparam logic [5:0] IDX_SENSE = 6'h35;
	localparam logic [5:0] IDX_FLAGS = 6'h3A;
	localparam logic [5:0] IDX_MASK = 6'h3B;
	localparam logic [5:0] IDX_REF = 6'h08;
	// field positions
	localparam int WDT_BIT = 3;
	localparam int BOD_BIT = 2;
	localparam int PINRST_BIT = 1;
	localparam int POR_BIT = 0;
	localparam int EXT_BIT = 6;
	localparam int PC_BIT = 5;
	localparam int CONV_BIT = 0;
	localparam int CBS_BIT = 1;
	localparam int BG_ON_BIT = 2;
	localparam int REF_READY_BIT = 3;
	localparam int GIE_BIT = 4;
	// reset values
	localparam logic [3:0] RESET_CAUSE_RST = 4'h1;
	localparam logic [1:0] SENSE_RST = 2'h0;
	// external pin sense codes
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	// vectors; timer sources follow the pin change vector
	localparam logic [8:0] VEC_EXT = 9'h001;
	localparam logic [8:0] VEC_PC = 9'h002;
	localparam int NUM_SRC = 5;
	localparam int PIN_COUNT = 6;
	// timing
	localparam logic [3:0] ENTRY_CYCLES = 4'h4;
	localparam logic [3:0] SLEEP_EXTRA_CYCLES = 4'h4;
	localparam logic [3:0] RETURN_CYCLES = 4'h4;
	localparam int REF_STARTUP_NS = 10000;
	localparam int REF_STARTUP_CYCLES = (REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {IRQRC_IDLE, IRQRC_ENTRY, IRQRC_RET} irqrc_fsm_type;

	typedef struct packed {
		logic slot;
		logic return_from_interrupt;
		logic gie_set;
		logic gie_clr;
		logic sleeping;
		logic [8:0] pc;
	} irqrc_core_in_type;

	typedef struct packed {
		logic hold;
		logic push;
		logic pop;
		logic [8:0] push_pc;
		logic vector_load;
		logic [8:0] vector;
		logic gie;
		logic [2:0] timer_ack;
	} irqrc_core_out_type;

	typedef struct packed {
		irqrc_fsm_type fsm;
		logic [3:0] cnt;
		logic slow;
		logic [2:0] src;
		logic gie;
		logic need_instr;
		logic [3:0] cause;
		logic en_ext;
		logic en_pc;
		logic ext_flag;
		logic pc_flag;
		logic [1:0] sense;
		logic conv_en;
		logic cbs;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic ext_stable;
		logic [PIN_COUNT-1:0] pin_s1;
		logic [PIN_COUNT-1:0] pin_s2;
		logic [PIN_COUNT-1:0] pin_s3;
		logic [PIN_COUNT-1:0] pin_stable;
		logic ack;
		logic [7:0] rdata;
		logic push;
		logic pop;
		logic [8:0] push_pc;
		logic vload;
		logic [8:0] vector;
		logic [2:0] timer_ack;
		logic bg_on;
		logic [7:0] ref_cnt;
		logic ref_ready;
	} irqrc_state_type;

	// pins idle high, so synchronisers start high to avoid a false change after reset
	localparam irqrc_state_type IRQRC_STATE_RST = '{fsm: IRQRC_IDLE, cause: RESET_CAUSE_RST,
		sense: SENSE_RST, ext_s1: 1'b1, ext_s2: 1'b1, ext_s3: 1'b1, ext_stable: 1'b1,
		pin_s1: '1, pin_s2: '1, pin_s3: '1, pin_stable: '1, default: '0};
endpackage
`default_nettype wire

// File: verif/irqrc_core_model.sv
/*
 * Processor core model facing the interrupt unit: slots, vector capture, handler, return.
 * Assumes the unit's core link contract; the bench steers stalls, sleep and global enable.
 */
`default_nettype none
module irqrc_core_model
	import irqrc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// bench controls
	input wire logic stall,
	input wire logic sleep_req,
	input wire logic [1:0] gie_req,
	// unit link
	input wire irqrc_core_out_type core_out,
	output irqrc_core_in_type core_in,
	// observation
	output logic [8:0] last_vec,
	output logic [7:0] vec_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left_q;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_in <= '0;
			last_vec <= '0;
			vec_count <= '0;
			left_q <= '0;
		end else begin
			core_in.slot <= !stall && !core_out.hold;
			core_in.gie_set <= gie_req[1];
			core_in.gie_clr <= gie_req[0];
			core_in.sleeping <= sleep_req;
			core_in.return_from_interrupt <= (left_q == 4'h1);
			if (core_in.slot) begin
				core_in.pc <= core_in.pc + 9'h001;
			end
			if (left_q != 4'h0) begin
				left_q <= left_q - 4'h1;
			end
			if (core_out.vector_load) begin
				left_q <= 4'h6;
				last_vec <= core_out.vector;
				vec_count <= vec_count + 8'h01;
			end
		end
	end
endmodule // irqrc_core_model
`default_nettype wire

// File: verif/irqrc_unit_bench.sv
/*
 * Self-checking bench of the interrupt and reset-cause unit, with bus tasks and random stimulus.
 * Assumes the core model beside the unit; bus waits follow waitrequest, not a fixed count.
 */
`default_nettype none
module irqrc_unit_bench
	import irqrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_RC = {IDX_RESET_CAUSE, 2'b00};
	localparam logic [7:0] A_SN = {IDX_SENSE, 2'b00};
	localparam logic [7:0] A_FL = {IDX_FLAGS, 2'b00};
	localparam logic [7:0] A_MK = {IDX_MASK, 2'b00};
	localparam logic [7:0] A_RF = {IDX_REF, 2'b00};
	logic sys_clk, sys_rst, ce, read, write, waitrequest, ext_pin, fuse, bandgap_on, stall, sleep_req;
	logic [7:0] address, vec_count, nv;
	logic [7:0] hold_run = 8'h00, last_hold = 8'h00, push_cnt = 8'h00, pop_cnt = 8'h00;
	logic [8:0] push_gap = 9'h000;
	logic [2:0] ack_seen = 3'h0;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, q, r;
	logic [PIN_COUNT-1:0] port_pins;
	logic [2:0] rst_evt, timer_req;
	logic [1:0] gie_req;
	logic [8:0] last_vec;
	irqrc_core_in_type core_in;
	irqrc_core_out_type core_out;
	int err_count, tests_run;

	irqrc_unit #(.REF_WAIT_CYCLES(4)) u_irqrc_unit (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
		.address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .core_in(core_in), .core_out(core_out),
		.ext_pin(ext_pin), .port_pins(port_pins), .wdt_reset_evt(rst_evt[2]), .bod_reset_evt(rst_evt[1]),
		.pin_reset_evt(rst_evt[0]), .brownout_detect_fuse(fuse), .timer_irq_req(timer_req),
		.bandgap_on(bandgap_on));
	irqrc_core_model u_irqrc_core_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall),
		.sleep_req(sleep_req), .gie_req(gie_req), .core_out(core_out), .core_in(core_in),
		.last_vec(last_vec), .vec_count(vec_count));

	////////////////////////////////////////////////////////////////////////////////
	// length of the last busy stretch of the core link, push and pop counts, last timer ack
	always @(posedge sys_clk) begin
		if (core_out.hold === 1'b1) begin
			hold_run <= hold_run + 8'h01;
		end else if (hold_run != 8'h00) begin
			last_hold <= hold_run;
			hold_run <= 8'h00;
		end
		// the model advanced its pc at the take slot, so the pushed pc trails it by one
		if (core_out.push === 1'b1) begin
			push_cnt <= push_cnt + 8'h01;
			push_gap <= core_in.pc - core_out.push_pc;
		end
		if (core_out.pop === 1'b1) begin
			pop_cnt <= pop_cnt + 8'h01;
		end
		if (core_out.timer_ack !== 3'h0) begin
			ack_seen <= core_out.timer_ack;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic timeout();
		err_count++;
		summarize();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		address <= a;
		writedata <= {24'h000000, d};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 20);
		if (k >= 20) timeout();
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(q, {24'h000000, e});
	endtask
	task automatic gie(input logic [1:0] v);
		gie_req <= v;
		cyc(1);
		gie_req <= 2'b00;
	endtask
	task automatic ext(input logic v);
		ext_pin <= v;
		cyc(6);
	endtask
	task automatic wait_vec(input logic [8:0] vec);
		int k;
		k = 0;
		nv = nv + 8'h01;
		while (vec_count !== nv && k < 300) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 300) timeout();
		check({23'h0, last_vec}, {23'h0, vec});
	endtask
	task automatic wait_gie();
		int k;
		k = 0;
		while (core_out.gie !== 1'b1 && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 100) timeout();
		cyc(2);
		check({24'h0, last_hold}, 32'h4);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		int i;
		sys_rst = 1'b1;
		ce = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = 32'h0;
		ext_pin = 1'b1;
		port_pins = '1;
		rst_evt = 3'h0;
		fuse = 1'b0;
		timer_req = 3'h0;
		stall = 1'b0;
		sleep_req = 1'b0;
		gie_req = 2'h0;
		nv = 8'h00;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32'h534F));
		cyc(3);
		sys_rst <= 1'b0;
		cyc(1);
		rdc(A_RC, 8'h01);
		rdc(A_MK, 8'h00);
		rdc(A_FL, 8'h00);
		rdc(A_SN, 8'h00);
		rdc(8'hFC, 8'h00);
		rdc(A_RC + 8'h01, 8'h00);
		r = 32'h01;
		for (i = 0; i < 3; i++) begin
			rst_evt <= 3'b001 << i;
			cyc(1);
			rst_evt <= 3'b000;
			r = r | (32'h02 << i);
			rdc(A_RC, r[7:0]);
		end
		bus(1'b1, A_RC, 8'h0E);
		rdc(A_RC, 8'h0E);
		// a write without lane 0 enabled must not clear anything
		byteenable <= 4'hE;
		bus(1'b1, A_RC, 8'h00);
		byteenable <= 4'hF;
		rdc(A_RC, 8'h0E);
		bus(1'b1, A_RC, 8'h00);
		rdc(A_RC, 8'h00);
		rst_evt <= 3'b100;
		cyc(1);
		rst_evt <= 3'b000;
		rdc(A_RC, 8'h08);
		for (i = 0; i < 8; i++) begin
			r = $urandom;
			fuse <= r[0];
			bus(1'b1, A_RF, {6'h00, r[2:1]});
			cyc(2);
			check({31'h0, bandgap_on}, {31'h0, |r[2:0]});
		end
		fuse <= 1'b0;
		bus(1'b1, A_RF, 8'h00);
		cyc(2);
		// clock enable low freezes the bandgap register
		ce <= 1'b0;
		fuse <= 1'b1;
		cyc(4);
		check({31'h0, bandgap_on}, 32'h0);
		ce <= 1'b1;
		cyc(2);
		check({31'h0, bandgap_on}, 32'h1);
		fuse <= 1'b0;
		cyc(2);
		bus(1'b1, A_RF, 8'h02);
		i = 0;
		do begin
			bus(1'b0, A_RF, 8'h00);
			i++;
		end while (q[REF_READY_BIT] !== 1'b1 && i < 20);
		check({31'h0, q[REF_READY_BIT]}, 32'h1);
		check({24'h0, q[7:0]}, 32'h0E);
		// every sense code with the enable still clear
		for (i = 0; i < 4; i++) begin
			bus(1'b1, A_SN, i[7:0]);
			ext(1'b0);
			rdc(A_FL, (i == 1 || i == 2) ? 8'h40 : 8'h00);
			bus(1'b1, A_FL, 8'h40);
			rdc(A_FL, 8'h00);
			ext(1'b1);
			rdc(A_FL, (i == 1 || i == 3) ? 8'h40 : 8'h00);
			bus(1'b1, A_FL, 8'h40);
		end
		bus(1'b1, A_SN, {6'h00, SENSE_FALL});
		bus(1'b1, A_MK, 8'h40);
		gie(2'b10);
		ext_pin <= 1'b0;
		wait_vec(VEC_EXT);
		check({31'h0, core_out.gie}, 32'h0);
		check({24'h0, last_hold}, 32'h4);
		rdc(A_FL, 8'h00);
		wait_gie();
		// three sources pend behind a clear global enable
		ext(1'b1);
		gie(2'b01);
		bus(1'b1, A_MK, 8'h60);
		ext(1'b0);
		r = $urandom % PIN_COUNT;
		port_pins[r[2:0]] <= ~port_pins[r[2:0]];
		timer_req <= 3'b001;
		cyc(8);
		check({24'h0, vec_count}, {24'h0, nv});
		rdc(A_FL, 8'h60);
		gie(2'b10);
		wait_vec(VEC_EXT);
		wait_vec(VEC_PC);
		wait_vec(VEC_PC + 9'h001);
		check({29'h0, ack_seen}, 32'h1);
		timer_req <= 3'b000;
		wait_gie();
		rdc(A_FL, 8'h00);
		ext(1'b1);
		sleep_req <= 1'b1;
		ext_pin <= 1'b0;
		wait_vec(VEC_EXT);
		check({24'h0, last_hold}, 32'h8);
		sleep_req <= 1'b0;
		wait_gie();
		ext(1'b1);
		stall <= 1'b1;
		ext(1'b0);
		cyc(6);
		check({24'h0, vec_count}, {24'h0, nv});
		stall <= 1'b0;
		wait_vec(VEC_EXT);
		wait_gie();
		ext(1'b1);
		bus(1'b1, A_SN, {6'h00, SENSE_LOW});
		ext_pin <= 1'b0;
		wait_vec(VEC_EXT);
		ext_pin <= 1'b1;
		wait_gie();
		cyc(20);
		check({24'h0, vec_count}, {24'h0, nv});
		check({24'h0, push_cnt}, {24'h0, nv});
		check({24'h0, pop_cnt}, {24'h0, nv});
		check({23'h0, push_gap}, 32'h1);
		summarize();
	end
endmodule // irqrc_unit_bench
`default_nettype wire
